// >>> design/cssc_cfg.svh
/*
  Constants of the character-set selection control: register map,
  strap layout, shift codes and timing.
  Assumes inclusion by bare name from each design file that needs it.
*/
// What this block does
// RQ1: Bit-8 mode drops parity-error monitoring entirely
// RQ2: Bit-8 mode ignores panel switches and shift codes
// RQ3: Bit 8 feeds output stage, taken on option strobe
// RQ4: Bit 8 high standard, low alternate set
// RQ5: Cut group strap forces standard set for its group
// RQ6: Lock switch up: shift codes switch sets
// RQ7: Logic board sends ~50 ns character-test pulse
// RQ8: Both switches down: primary lamp off unless strap one fitted
// RQ9: Shift-out 016 alternate, shift-in 017 standard
// RQ10: Panel switches override remote clock and data
// RQ11: Parity error in alternate set inhibits substitution
// RQ12: Two selection stages: command then option strobe
`ifndef CSSC_CFG_SVH
`define CSSC_CFG_SVH

`define CSSC_ADDR_W 8
`define CSSC_CTRL_OFS 8'h00
`define CSSC_STAT_OFS 8'h04
`define CSSC_COUNT_OFS 8'h08

// Straps: bit0 strap one, bit1 strap two, bits2-4 group, bit5-6 bit-8 pair
`define CSSC_STRAP_W 7
`define CSSC_CTRL_RST 7'h1f
`define CSSC_STAT_RUNT_BIT 7

`define CSSC_SO_CODE 7'h0e
`define CSSC_SI_CODE 7'h0f

`define CSSC_CLK_NS 4
`define CSSC_CHAR_TEST_NS 50
`define CSSC_CHAR_TEST_CYC ((`CSSC_CHAR_TEST_NS + `CSSC_CLK_NS - 1) / `CSSC_CLK_NS)
`define CSSC_RUNT_CYC (`CSSC_CHAR_TEST_CYC / 4)
`define CSSC_WCNT_W 5
`define CSSC_CNT_W 16

`endif

// >>> design/cssc_pkg.sv
/*
  Types of the character-set selection control.
  Assumes cssc_cfg.svh for widths.
*/
`include "cssc_cfg.svh"
package cssc_pkg;

  // Straps as software sees them in the control register
  typedef struct packed {
    logic bit8_aux_strap;
    logic bit8_route_strap;
    logic lower_group_strap;
    logic upper_group_strap;
    logic figures_group_strap;
    logic strap_two;
    logic strap_one;
  } cssc_straps_t;

  // Logic-board and panel pins, synchronised as one group
  typedef struct packed {
    logic lock_down;
    logic secondary_set_switch;
    logic char_test;
    logic option_sample_strobe;
    logic parity_error;
    logic [2:0] group_hit;
    logic [7:0] char_data;
  } cssc_pins_t;

  typedef struct packed {
    logic [23:0] reserved;
    logic test_pulse_short;
    logic parity_inhibit;
    logic local_control;
    logic bit8_mode;
    logic secondary_lamp;
    logic primary_set_lamp;
    logic stage2_std;
    logic stage1_std;
  } cssc_status_t;

endpackage

// >>> design/cssc_sync.sv
/*
  Two-flop synchroniser for a group of pin levels.
  Assumes every bit changes slowly compared with the clock.
*/
module cssc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// >>> design/cssc_shift_decode.sv
/*
  Shift-code decoder: recognises the two set-change control codes
  in the low seven bits of a received character.
  Assumes the character is stable when its test strobe is seen.
*/
`include "cssc_cfg.svh"
module cssc_shift_decode (
  // Character
  input wire logic [6:0] code,
  // Decoded commands
  output logic shift_out,
  output logic shift_in
);
  assign shift_out = (code == `CSSC_SO_CODE); // RQ9
  assign shift_in = (code == `CSSC_SI_CODE); // RQ9
endmodule

// >>> design/cssc_top.sv
/*
  Character-set selection control: picks the standard or alternate
  glyph set for the print head from panel switches, shift codes or
  data bit 8, with per-group straps and an APB register file.
  Assumes panel and logic-board pins are asynchronous to clk and
  that strobes stay high for several clock periods.
*/
`include "cssc_cfg.svh"
module cssc_top (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic [`CSSC_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Front panel switches
  input wire logic lock_switch_down,
  input wire logic secondary_set_switch,
  // Logic board
  input wire logic [7:0] char_data,
  input wire logic char_test,
  input wire logic option_sample_strobe,
  input wire logic parity_error,
  input wire logic [2:0] group_hit,
  // Line driver enables and lamps
  output logic alternate_drive_en,
  output logic standard_drive_en,
  output logic primary_set_lamp,
  output logic secondary_lamp
);
  import cssc_pkg::*;

  cssc_pins_t raw_pins;
  cssc_pins_t pins;
  cssc_straps_t straps;
  cssc_status_t status;
  logic [`CSSC_STRAP_W-1:0] ctrl;
  logic test_d;
  logic strobe_d;
  logic test_rise;
  logic test_fall;
  logic strobe_rise;
  logic shift_out;
  logic shift_in;
  logic bit8_mode;
  logic local_control;
  logic stage1_std;
  logic stage2_std;
  logic next_stage2;
  logic group_qualify;
  logic parity_inhibit;
  logic select_alt;
  logic [`CSSC_WCNT_W-1:0] test_width;
  logic test_pulse_short;
  logic runt_event;
  logic [`CSSC_CNT_W-1:0] shift_count;
  logic cmd_taken;
  logic setup;
  logic access;
  logic wr;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_count;
  logic mapped;
  logic next_stage1;
  logic [2:0] group_enable;
  logic next_primary;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_count;
  logic [31:0] next_prdata;

  // Pins
  assign raw_pins = '{
    lock_down: lock_switch_down,
    secondary_set_switch: secondary_set_switch,
    char_test: char_test,
    option_sample_strobe: option_sample_strobe,
    parity_error: parity_error,
    group_hit: group_hit,
    char_data: char_data
  };

  cssc_sync #(
    .W($bits(cssc_pins_t))
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(raw_pins),
    .sync_out(pins)
  );

  // Edge detectors look only at the second synchroniser stage
  // Reset low matches the idle pin level, so no false edge after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      test_d <= 1'b0;
      strobe_d <= 1'b0;
    end else begin
      test_d <= pins.char_test;
      strobe_d <= pins.option_sample_strobe;
    end
  end

  assign test_rise = pins.char_test && !test_d;
  assign test_fall = !pins.char_test && test_d;
  assign strobe_rise = pins.option_sample_strobe && !strobe_d;

  cssc_shift_decode u_decode (
    .code(pins.char_data[6:0]),
    .shift_out(shift_out),
    .shift_in(shift_in)
  );

  // Mode
  // Bit-8 mode needs both selection straps cut and both bit-8 straps fitted
  assign straps = cssc_straps_t'(ctrl);
  assign bit8_mode = !straps.strap_one && !straps.strap_two &&
                     straps.bit8_route_strap && straps.bit8_aux_strap; // RQ2
  assign local_control = !bit8_mode && pins.lock_down; // RQ2
  // Shift codes count only once the panel has released control
  assign cmd_taken = !bit8_mode && !pins.lock_down && test_rise &&
                     (shift_out || shift_in); // RQ6

  // First stage: panel switches win over any shift command
  // Switch override is synchronous, so a held switch still needs
  // the option strobe before the print head sees it
  always_comb begin
    next_stage1 = stage1_std;
    if (local_control) begin
      next_stage1 = !pins.secondary_set_switch; // RQ10
    end else if (cmd_taken) begin
      next_stage1 = shift_in; // RQ9
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_std <= 1'b1;
    end else begin
      stage1_std <= next_stage1;
    end
  end

  // Second stage: bit 8 replaces the first stage in bit-8 mode
  assign next_stage2 = bit8_mode ? pins.char_data[7] : stage1_std; // RQ3

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage2_std <= 1'b1;
    end else if (strobe_rise) begin
      stage2_std <= next_stage2; // RQ12
    end
  end

  // Substitution
  assign group_enable = {straps.lower_group_strap, straps.upper_group_strap,
                         straps.figures_group_strap}; // RQ5
  assign group_qualify = |(pins.group_hit & group_enable); // RQ5
  // Parity checking is meaningless when bit 8 carries the selection
  assign parity_inhibit = pins.parity_error && !bit8_mode && !stage2_std; // RQ1
  assign select_alt = !stage2_std && group_qualify && !parity_inhibit; // RQ4

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alternate_drive_en <= 1'b0;
      standard_drive_en <= 1'b1;
    end else begin
      alternate_drive_en <= select_alt; // RQ11
      standard_drive_en <= !select_alt; // RQ11
    end
  end

  // A fitted strap one keeps this lamp lit under local alternate
  // selection, copying the known wiring fault
  assign next_primary = stage2_std ||
                        (straps.strap_one && local_control &&
                         pins.secondary_set_switch); // RQ8

  // Lamps ignore the group straps on purpose
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      primary_set_lamp <= 1'b1;
      secondary_lamp <= 1'b0;
    end else begin
      primary_set_lamp <= next_primary; // RQ8
      secondary_lamp <= !stage2_std;
    end
  end

  // Test pulse width watch; a runt often means a cabling fault
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      test_width <= '0;
    end else if (test_rise) begin
      test_width <= `CSSC_WCNT_W'(1);
    end else if (pins.char_test && test_width != '1) begin
      test_width <= test_width + `CSSC_WCNT_W'(1);
    end
  end

  assign runt_event = test_fall && (test_width < `CSSC_WCNT_W'(`CSSC_RUNT_CYC)); // RQ7

  // Bus
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wr = access && pwrite;
  assign wr_ctrl = wr && hit_ctrl;
  assign wr_stat = wr && hit_stat;
  assign wr_count = wr && hit_count;
  // Zero wait states: every register answers in its access cycle
  assign pready = 1'b1;

  always_comb begin
    hit_ctrl = 1'b0;
    hit_stat = 1'b0;
    hit_count = 1'b0;
    if (paddr == `CSSC_CTRL_OFS) begin
      hit_ctrl = 1'b1;
    end else if (paddr == `CSSC_STAT_OFS) begin
      hit_stat = 1'b1;
    end else if (paddr == `CSSC_COUNT_OFS) begin
      hit_count = 1'b1;
    end
  end

  assign mapped = hit_ctrl || hit_stat || hit_count;
  assign pslverr = access && !mapped;

  // Straps live in software; reset fits the usual selection straps
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `CSSC_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl <= pwdata[`CSSC_STRAP_W-1:0];
    end
  end

  // Sticky runt flag: a new runt wins over a write-one clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      test_pulse_short <= 1'b0;
    end else if (runt_event) begin
      test_pulse_short <= 1'b1;
    end else if (wr_stat && pwdata[`CSSC_STAT_RUNT_BIT]) begin
      test_pulse_short <= 1'b0;
    end
  end

  // Accepted shift commands; counting wins over a clearing write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_count <= '0;
    end else if (cmd_taken) begin
      shift_count <= shift_count + `CSSC_CNT_W'(1);
    end else if (wr_count) begin
      shift_count <= '0;
    end
  end

  assign status = '{
    reserved: '0,
    test_pulse_short: test_pulse_short,
    parity_inhibit: parity_inhibit,
    local_control: local_control,
    bit8_mode: bit8_mode,
    secondary_lamp: secondary_lamp,
    primary_set_lamp: primary_set_lamp,
    stage2_std: stage2_std,
    stage1_std: stage1_std
  };

  // Read data captured in the setup cycle, held through access
  // Holding it until the next read lets a slow master sample late
  always_comb begin
    next_prdata = prdata;
    if (setup && !pwrite) begin
      if (hit_ctrl) begin
        next_prdata = {{(32 - `CSSC_STRAP_W){1'b0}}, ctrl};
      end else if (hit_stat) begin
        next_prdata = status;
      end else if (hit_count) begin
        next_prdata = {{(32 - `CSSC_CNT_W){1'b0}}, shift_count};
      end else begin
        next_prdata = '0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= '0;
    end else begin
      prdata <= next_prdata;
    end
  end
endmodule

// >>> tb/cssc_top_assertions.sv
/*
  Port checker for cssc_top: APB answers, drive and lamp relations.
  Assumes binding to cssc_top with ports named as in its header.
*/
`include "cssc_cfg.svh"
module cssc_top_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB
  input wire logic [`CSSC_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Strobe, drivers and lamps
  input wire logic option_sample_strobe,
  input wire logic alternate_drive_en,
  input wire logic standard_drive_en,
  input wire logic primary_set_lamp,
  input wire logic secondary_lamp
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic bad;
  logic rd_setup;
  assign bad = paddr != `CSSC_CTRL_OFS && paddr != `CSSC_STAT_OFS &&
               paddr != `CSSC_COUNT_OFS;
  assign rd_setup = psel && !penable && !pwrite;
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  chk_ready_access: assert property (s_access |-> pready) else $error("pready low");
  chk_setup_no_err: assert property (s_setup |-> !pslverr) else $error("early pslverr");
  chk_unmapped_err: assert property (s_setup ##1 s_access |-> pslverr == bad)
    else $error("pslverr wrong");
  chk_unmapped_zero: assert property (s_setup ##1 (s_access and (!pwrite && bad)) |-> !prdata)
    else $error("unmapped read not zero");
  chk_rdata_hold: assert property ($changed(prdata) |-> $past(rd_setup))
    else $error("prdata moved");
  chk_drive_pair: assert property (standard_drive_en != alternate_drive_en)
    else $error("drivers not exclusive");
  chk_alt_needs_set: assert property (alternate_drive_en |-> secondary_lamp)
    else $error("alternate drive without set");
  chk_primary_off: assert property (!primary_set_lamp |-> secondary_lamp)
    else $error("no lamp lit");
  // Secondary lamp moves only four edges after a strobe rise
  chk_lamp_strobe: assert property ($changed(secondary_lamp) |->
    $past(option_sample_strobe, 4) && !$past(option_sample_strobe, 5))
    else $error("lamp moved without strobe");
endmodule

bind cssc_top cssc_top_assertions i_chk (.clk, .rst_n, .paddr, .psel, .penable, .pwrite,
  .prdata, .pready, .pslverr, .option_sample_strobe, .alternate_drive_en,
  .standard_drive_en, .primary_set_lamp, .secondary_lamp);

// >>> tb/cssc_board.sv
/*
  Logic-board model: character, test pulse, option strobe, parity, group.
  Assumes its tasks are called just after a rising clock edge.
*/
module cssc_board (
  // Clock
  input wire logic clk,
  // Board pins
  output logic [7:0] char_data,
  output logic char_test,
  output logic option_sample_strobe,
  output logic parity_error,
  output logic [2:0] group_hit
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    char_data = 8'h00;
    char_test = 1'h0;
    option_sample_strobe = 1'h0;
    parity_error = 1'h0;
    group_hit = 3'h1;
  end
  // Data held around the pulse so the decoder never sees a change
  task automatic send_char(input logic [7:0] c);
    char_data <= c;
    @(posedge clk);
    char_test <= 1'h1;
    repeat (13) @(posedge clk);
    char_test <= 1'h0;
    repeat (4) @(posedge clk);
  endtask
  // Test pulse far shorter than the logic board ever sends
  task automatic runt_pulse;
    char_test <= 1'h1;
    repeat (2) @(posedge clk);
    char_test <= 1'h0;
    repeat (4) @(posedge clk);
  endtask
  task automatic pulse_strobe;
    option_sample_strobe <= 1'h1;
    repeat (4) @(posedge clk);
    option_sample_strobe <= 1'h0;
    repeat (6) @(posedge clk);
  endtask
  task automatic set_flags(input logic p, input logic [2:0] g);
    parity_error <= p;
    group_hit <= g;
    repeat (6) @(posedge clk);
  endtask
endmodule

// >>> tb/char_set_select_control_bench.sv
/*
  Testbench of cssc_top: APB tasks, panel switches, board model.
  Assumes the design files and the board model are compiled first.
*/
`include "cssc_cfg.svh"
module char_set_select_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0;
  logic rst_n;
  logic [7:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err;
  logic lock_switch_down;
  logic secondary_set_switch;
  logic [7:0] char_data;
  logic char_test, option_sample_strobe, parity_error;
  logic [2:0] group_hit;
  logic alternate_drive_en, standard_drive_en, primary_set_lamp, secondary_lamp;
  int bad_count = 0;
  int checks = 0;

  cssc_top i_dut (.clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .lock_switch_down, .secondary_set_switch, .char_data, .char_test,
    .option_sample_strobe, .parity_error, .group_hit, .alternate_drive_en,
    .standard_drive_en, .primary_set_lamp, .secondary_lamp);
  cssc_board i_board (.clk, .char_data, .char_test, .option_sample_strobe, .parity_error,
    .group_hit);

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic print_verdict;
    if (bad_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // Expected order: alternate drive, standard drive, primary lamp, secondary lamp
  task automatic outs(input logic [3:0] e);
    cmp("outputs", {28'h0, e}, {28'h0, alternate_drive_en, standard_drive_en,
      primary_set_lamp, secondary_lamp});
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (n == 16) begin
      bad_count++;
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask

  task automatic panel(input logic l, input logic s);
    lock_switch_down <= l;
    secondary_set_switch <= s;
    repeat (4) @(posedge clk);
    i_board.pulse_strobe();
  endtask

  initial begin
    rst_n <= 1'h0;
    paddr <= 8'h00;
    psel <= 1'h0;
    penable <= 1'h0;
    pwrite <= 1'h0;
    pwdata <= 32'h0;
    lock_switch_down <= 1'h0;
    secondary_set_switch <= 1'h0;
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    outs(4'h6);
    apb(1'h0, 8'h00, 32'h0);
    cmp("ctrl", 32'h1f, rd);
    apb(1'h0, 8'h0c, 32'h0);
    cmp("unmapped data", 32'h0, rd);
    cmp("unmapped error", 32'h1, {31'h0, err});
    panel(1'h1, 1'h1);
    outs(4'hb);
    apb(1'h1, 8'h00, 32'h1e);
    i_board.pulse_strobe();
    outs(4'h9);
    panel(1'h1, 1'h0);
    outs(4'h6);
    panel(1'h0, 1'h0);
    apb(1'h1, 8'h08, 32'h0);
    i_board.send_char(8'h0e);
    i_board.pulse_strobe();
    outs(4'h9);
    i_board.send_char(8'h0f);
    i_board.pulse_strobe();
    outs(4'h6);
    i_board.send_char(8'h0e);
    i_board.pulse_strobe();
    // Figures group cut: that group always prints standard
    apb(1'h1, 8'h00, 32'h1a);
    i_board.set_flags(1'h0, 3'h1);
    outs(4'h5);
    i_board.set_flags(1'h0, 3'h2);
    outs(4'h9);
    i_board.set_flags(1'h1, 3'h2);
    outs(4'h5);
    i_board.set_flags(1'h0, 3'h2);
    apb(1'h1, 8'h00, 32'h7c);
    panel(1'h1, 1'h0);
    i_board.send_char(8'h41);
    i_board.pulse_strobe();
    outs(4'h9);
    apb(1'h0, 8'h04, 32'h0);
    cmp("status", 32'h18, rd);
    i_board.set_flags(1'h1, 3'h2);
    outs(4'h9);
    i_board.send_char(8'h8f);
    i_board.pulse_strobe();
    outs(4'h6);
    lock_switch_down <= 1'h0;
    i_board.send_char(8'h8e);
    i_board.pulse_strobe();
    outs(4'h6);
    apb(1'h0, 8'h08, 32'h0);
    cmp("count", 32'h3, rd);
    i_board.runt_pulse();
    apb(1'h0, 8'h04, 32'h0);
    cmp("status", 32'h96, rd);
    apb(1'h1, 8'h04, 32'h80);
    apb(1'h0, 8'h04, 32'h0);
    cmp("status", 32'h16, rd);
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    print_verdict();
  end
endmodule
